// ==== crt_pkg.sv ====
// Constants, types and command codes for the current-channel mode, range and trigger controller
package crt_pkg;
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_ARG = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_AMP = 8'h0C;
	localparam logic [7:0] OFS_VOLT = 8'h10;
	localparam logic [7:0] OFS_AMP_PEND = 8'h14;
	localparam logic [7:0] OFS_VOLT_PEND = 8'h18;
	localparam logic [7:0] OFS_ERROR = 8'h1C;
	localparam logic [7:0] OFS_TRAN_LEFT = 8'h20;
	localparam int SLOTS = 16;
	localparam int SLOT_W = 4;
	localparam logic signed [15:0] LEVEL_MAX = 16'sh7FFF;
	localparam logic [15:0] QUARTER = 16'h1FFF;
	localparam logic [2:0] RANGE_FULL_CODE = 3'h1;
	localparam logic [2:0] RANGE_QUARTER_CODE = 3'h4;
	localparam logic signed [15:0] ERR_NONE = 16'sh0000;
	localparam logic signed [15:0] ERR_COMMAND = -16'sd100;
	localparam logic signed [15:0] ERR_WARNING = -16'sd211;
	localparam logic signed [15:0] ERR_CONFLICT = -16'sd221;
	localparam logic signed [15:0] ERR_RANGE = -16'sd222;
	localparam int TRAN_MAX_S = 10;
	localparam logic [31:0] TRAN_MAX_MS = 32'(TRAN_MAX_S * 1000);
	localparam int CLK_PERIOD_PS = 4000;
	localparam int MS_PS = 1000000000;
	localparam int TICKS_PER_MS = MS_PS / CLK_PERIOD_PS;
	localparam logic [31:0] AHB_OKAY = 32'h0;
	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_MODE_FIX = 5'h01, OP_MODE_LIST = 5'h02, OP_MODE_TRAN = 5'h03,
		OP_CURR = 5'h04, OP_VOLT = 5'h05, OP_AMP_RANGE = 5'h06, OP_AMP_AUTO = 5'h07,
		OP_VOLT_AUTO = 5'h08, OP_VOLT_RANGE = 5'h09, OP_AMP_TRIG = 5'h0A, OP_VOLT_TRIG = 5'h0B,
		OP_FUNC_TRIG = 5'h0C, OP_FUNC = 5'h0D, OP_TRG = 5'h0E, OP_INIT = 5'h0F,
		OP_SAV = 5'h10, OP_RCL = 5'h11, OP_RST = 5'h12, OP_LIST_VOLT = 5'h13,
		OP_LIST_CURR = 5'h14, OP_INIT_CONT = 5'h15
	} crt_op_type;
	typedef enum logic [1:0] {
		MODE_FIXED = 2'b00,
		MODE_TRAN = 2'b01,
		MODE_LIST = 2'b11
	} crt_mode_type;
	typedef struct packed {
		logic signed [15:0] volt;
		logic signed [15:0] amp;
		logic func;
	} crt_slot_type;
	typedef struct packed {
		logic signed [15:0] volt;
		logic signed [15:0] amp;
		logic func;
		logic amp_full;
		logic volt_full;
	} crt_out_type;
	typedef struct packed {
		logic start;
		logic abort;
		logic wr;
		logic wr_amp;
		logic signed [15:0] data;
		logic signed [15:0] vlimit;
	} crt_list_type;
	typedef struct packed {
		logic signed [15:0] volt;
		logic signed [15:0] amp;
		logic valid;
		logic last;
	} crt_step_type;
endpackage : crt_pkg

// ==== crt_ctl.sv ====
// Current-channel mode, range and trigger controller with an AHB-Lite register slave
//
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module crt_ctl #(
	parameter int TICKS_PER_MS = crt_pkg::TICKS_PER_MS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire crt_pkg::crt_step_type list_step,
	output crt_pkg::crt_out_type out_set,
	output crt_pkg::crt_list_type list_ctl,
	output crt_pkg::crt_mode_type mode,
	output logic err_pulse,
	output logic signed [15:0] err_code
);
	import crt_pkg::*;

	typedef struct packed {
		crt_mode_type mode;
		crt_out_type o;
		crt_slot_type pend;
		logic amp_autoscale_enable;
		logic volt_autoscale_enable;
		logic trig_init;
		logic trig_cont;
		logic pulse_on;
		logic signed [15:0] prior_amp;
		logic [31:0] tran_ms;
		logic [31:0] ms_left;
		logic [31:0] tick;
		crt_step_type prev_step;
		crt_step_type last_step;
		crt_slot_type [SLOTS-1:0] mem;
		logic [31:0] arg;
		logic signed [15:0] err_last;
		logic err_p;
		crt_list_type lst;
		logic [7:0] dph_addr;
		logic dph_write;
		logic [31:0] rdata;
	} crt_state_type;

	crt_state_type st;
	crt_state_type next_st;

	logic cmd_go;
	crt_op_type op;
	logic signed [15:0] arg16;
	logic [SLOT_W-1:0] slot;

	function automatic logic [15:0] crt_mag(input logic signed [15:0] v);
		crt_mag = v[15] ? 16'(-v) : 16'(v);
	endfunction : crt_mag

	// Commands execute in the data phase of a write to the command register
	assign cmd_go = st.dph_write && (st.dph_addr == OFS_CMD);
	assign op = crt_op_type'(hwdata[4:0]);
	assign arg16 = st.arg[15:0];
	assign slot = st.arg[SLOT_W-1:0];

	always_comb begin
		next_st = st;
		next_st.err_p = 1'b0;
		next_st.lst.start = 1'b0;
		next_st.lst.abort = 1'b0;
		next_st.lst.wr = 1'b0;

		// AHB-Lite: capture address phase, zero wait states
		next_st.dph_write = 1'b0;
		if (hsel && hready && htrans[1]) begin
			next_st.dph_addr = haddr[7:0];
			next_st.dph_write = hwrite;
			case (haddr[7:0])
				OFS_ARG: next_st.rdata = st.arg;
				OFS_STATUS: next_st.rdata = {16'h0000, 2'b00, st.pend.func, st.o.func, st.trig_cont,
					st.trig_init, st.pulse_on, st.volt_autoscale_enable, st.amp_autoscale_enable,
					st.o.volt_full ? RANGE_FULL_CODE : RANGE_QUARTER_CODE, 1'b0,
					st.o.amp_full ? RANGE_FULL_CODE : RANGE_QUARTER_CODE};
				OFS_AMP: next_st.rdata = 32'(st.o.amp);
				OFS_VOLT: next_st.rdata = 32'(st.o.volt);
				OFS_AMP_PEND: next_st.rdata = 32'(st.pend.amp);
				OFS_VOLT_PEND: next_st.rdata = 32'(st.pend.volt);
				OFS_ERROR: next_st.rdata = {{16{st.err_last[15]}}, st.err_last};
				OFS_TRAN_LEFT: next_st.rdata = st.ms_left;
				default: next_st.rdata = 32'h0;
			endcase
			if (haddr[7:0] == OFS_STATUS) begin
				next_st.rdata[15:14] = st.mode;
			end
		end
		if (st.dph_write && st.dph_addr == OFS_ARG) begin
			next_st.arg = hwdata;
		end
		if (st.dph_write && st.dph_addr == OFS_ERROR) begin
			next_st.err_last = ERR_NONE;
		end

		// List sequencer steps; last-but-one step is kept on completion
		if (st.mode == MODE_LIST && list_step.valid) begin
			next_st.prev_step = st.last_step;
			next_st.last_step = list_step;
			next_st.o.volt = list_step.volt;
			next_st.o.amp = list_step.amp;
			if (list_step.last) begin
				next_st.o.volt = st.last_step.volt;
				next_st.o.amp = st.last_step.amp;
				next_st.mode = MODE_FIXED;
			end
		end

		// Transient pulse timer in milliseconds
		if (st.pulse_on) begin
			if (st.tick == 32'(TICKS_PER_MS - 1)) begin
				next_st.tick = 32'h0;
				next_st.ms_left = st.ms_left - 32'h1;
				if (st.ms_left <= 32'h1) begin
					next_st.pulse_on = 1'b0;
					next_st.ms_left = 32'h0;
					next_st.o.amp = st.prior_amp;
				end
			end else begin
				next_st.tick = st.tick + 32'h1;
			end
		end

		if (cmd_go) begin
			case (op)
				OP_MODE_FIX: begin
					if (st.mode == MODE_LIST) begin
						next_st.o.volt = 16'sh0000;
						next_st.o.amp = 16'sh0000;
						next_st.lst.vlimit = 16'sh0000;
						next_st.lst.abort = 1'b1;
					end
					next_st.mode = MODE_FIXED;
				end
				OP_MODE_LIST: begin
					if (st.mode != MODE_LIST) begin
						next_st.mode = MODE_LIST;
						next_st.lst.start = 1'b1;
						next_st.lst.vlimit = st.o.volt;
						next_st.last_step = st.last_step;
					end
				end
				OP_MODE_TRAN: begin
					if (st.mode == MODE_LIST) begin
						next_st.err_p = 1'b1;
						next_st.err_last = ERR_CONFLICT;
					end else if (st.arg > TRAN_MAX_MS || st.arg == 32'h0) begin
						next_st.err_p = 1'b1;
						next_st.err_last = ERR_RANGE;
					end else begin
						next_st.mode = MODE_TRAN;
						next_st.tran_ms = st.arg;
					end
				end
				OP_CURR: begin
					if (st.mode == MODE_LIST) begin
						next_st.err_p = 1'b1;
						next_st.err_last = ERR_CONFLICT;
					end else if (crt_mag(arg16) > crt_mag(LEVEL_MAX) ||
						(!st.amp_autoscale_enable && !st.o.amp_full && crt_mag(arg16) > QUARTER)) begin
						next_st.err_p = 1'b1;
						next_st.err_last = ERR_RANGE;
					end else begin
						next_st.o.amp = arg16;
						if (st.amp_autoscale_enable) begin
							next_st.o.amp_full = crt_mag(arg16) > QUARTER;
						end
						if (st.mode == MODE_TRAN) begin
							// Pulse restores the level in force before this command, or before the pulse still running
							next_st.prior_amp = st.pulse_on ? st.prior_amp : st.o.amp;
							next_st.pulse_on = 1'b1;
							next_st.ms_left = st.tran_ms;
							next_st.tick = 32'h0;
							next_st.mode = MODE_FIXED;
						end
					end
				end
				OP_VOLT: begin
					if (st.mode == MODE_LIST) begin
						next_st.err_p = 1'b1;
						next_st.err_last = ERR_CONFLICT;
					end else if (crt_mag(arg16) > crt_mag(LEVEL_MAX)) begin
						next_st.err_p = 1'b1;
						next_st.err_last = ERR_RANGE;
					end else begin
						next_st.o.volt = arg16;
						if (st.volt_autoscale_enable) begin
							next_st.o.volt_full = crt_mag(arg16) > QUARTER;
						end
					end
				end
				OP_AMP_RANGE, OP_VOLT_RANGE: begin
					if (arg16 != 16'sh0001 && arg16 != 16'sh0004) begin
						next_st.err_p = 1'b1;
						next_st.err_last = ERR_RANGE;
					end else begin
						next_st.amp_autoscale_enable = 1'b0;
						next_st.volt_autoscale_enable = 1'b0;
						if (op == OP_AMP_RANGE) begin
							next_st.o.amp_full = (arg16 == 16'sh0001);
							if (!st.o.func) begin
								next_st.err_p = 1'b1;
								next_st.err_last = ERR_WARNING;
							end
						end else begin
							next_st.o.volt_full = (arg16 == 16'sh0001);
						end
					end
				end
				OP_AMP_AUTO, OP_VOLT_AUTO: begin
					if (st.arg == 32'h0) begin
						next_st.amp_autoscale_enable = 1'b0;
						next_st.volt_autoscale_enable = 1'b0;
					end else if (op == OP_AMP_AUTO) begin
						next_st.amp_autoscale_enable = 1'b1;
					end else begin
						next_st.volt_autoscale_enable = 1'b1;
					end
				end
				OP_AMP_TRIG: begin
					if (crt_mag(arg16) > crt_mag(LEVEL_MAX)) begin
						next_st.err_p = 1'b1;
						next_st.err_last = ERR_RANGE;
					end else begin
						next_st.pend.amp = arg16;
					end
				end
				OP_VOLT_TRIG: begin
					if (crt_mag(arg16) > crt_mag(LEVEL_MAX)) begin
						next_st.err_p = 1'b1;
						next_st.err_last = ERR_RANGE;
					end else begin
						next_st.pend.volt = arg16;
					end
				end
				OP_FUNC_TRIG: next_st.pend.func = st.arg[0];
				OP_FUNC: begin
					if (st.mode == MODE_LIST) begin
						next_st.err_p = 1'b1;
						next_st.err_last = ERR_COMMAND;
					end else begin
						next_st.o.func = st.arg[0];
						next_st.o.amp_full = 1'b1;
						next_st.o.volt_full = 1'b1;
					end
				end
				OP_TRG: begin
					if (st.trig_init && st.mode != MODE_LIST) begin
						next_st.o.volt = st.pend.volt;
						next_st.o.amp = st.pend.amp;
						next_st.o.func = st.pend.func;
						next_st.trig_init = st.trig_cont;
						if (st.amp_autoscale_enable) begin
							next_st.o.amp_full = crt_mag(st.pend.amp) > QUARTER;
						end
						if (st.mode == MODE_TRAN) begin
							next_st.prior_amp = st.pulse_on ? st.prior_amp : st.o.amp;
							next_st.pulse_on = 1'b1;
							next_st.ms_left = st.tran_ms;
							next_st.tick = 32'h0;
							next_st.mode = MODE_FIXED;
						end
					end
				end
				OP_INIT: next_st.trig_init = 1'b1;
				OP_INIT_CONT: begin
					next_st.trig_cont = st.arg[0];
					next_st.trig_init = st.arg[0];
				end
				OP_SAV: next_st.mem[slot] = st.pend;
				OP_RCL: begin
					next_st.pend = st.mem[slot];
					if (st.mode != MODE_LIST) begin
						next_st.o.volt = st.mem[slot].volt;
						next_st.o.amp = st.mem[slot].amp;
					end
				end
				OP_RST: begin
					next_st.o.volt = 16'sh0000;
					next_st.o.amp = 16'sh0000;
					next_st.o.func = 1'b0;
					next_st.o.amp_full = 1'b0;
					next_st.o.volt_full = 1'b0;
					next_st.amp_autoscale_enable = 1'b1;
					next_st.volt_autoscale_enable = 1'b1;
					next_st.lst.abort = (st.mode == MODE_LIST);
					next_st.mode = MODE_FIXED;
					next_st.pulse_on = 1'b0;
					next_st.trig_init = 1'b0;
					next_st.trig_cont = 1'b0;
				end
				OP_LIST_VOLT, OP_LIST_CURR: begin
					if (st.mode == MODE_LIST) begin
						next_st.err_p = 1'b1;
						next_st.err_last = ERR_CONFLICT;
					end else begin
						next_st.lst.wr = 1'b1;
						next_st.lst.wr_amp = (op == OP_LIST_CURR);
						next_st.lst.data = arg16;
					end
				end
				default: next_st.err_last = st.err_last;
			endcase
		end
	end

	// Power-up values match the reset command
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
			st.mode <= MODE_FIXED;
			st.amp_autoscale_enable <= 1'b1;
			st.volt_autoscale_enable <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign hrdata = st.rdata;
	assign hreadyout = 1'b1;
	assign hresp = AHB_OKAY[0];
	assign out_set = st.o;
	assign list_ctl = st.lst;
	assign mode = st.mode;
	assign err_pulse = st.err_p;
	assign err_code = st.err_last;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_rst_outputs: assert property (cmd_go && op == OP_RST |=>
		out_set.volt == 16'sh0000 && out_set.amp == 16'sh0000 && !out_set.func && mode == MODE_FIXED)
		else $error("reset command did not clear output");
	a_fix_abort: assert property (cmd_go && op == OP_MODE_FIX && mode == MODE_LIST |=>
		out_set.amp == 16'sh0000 && list_ctl.vlimit == 16'sh0000 && list_ctl.abort && mode == MODE_FIXED)
		else $error("list abort did not zero output");
	a_list_reject: assert property (cmd_go && mode == MODE_LIST &&
		(op == OP_LIST_VOLT || op == OP_LIST_CURR) |=> err_pulse && err_code == ERR_CONFLICT && !list_ctl.wr)
		else $error("list entry accepted while running");
	a_tran_long: assert property (cmd_go && op == OP_MODE_TRAN && mode != MODE_LIST &&
		st.arg > TRAN_MAX_MS |=> err_code == ERR_RANGE && mode == $past(mode))
		else $error("long transient not refused");
	// A running pulse or list may still move the output on its own
	a_trig_idle: assert property (cmd_go && op == OP_TRG && !st.trig_init && !st.pulse_on &&
		mode != MODE_LIST |=> $stable(out_set))
		else $error("trigger changed output without initiate");
	a_range_warn: assert property (cmd_go && op == OP_AMP_RANGE && !out_set.func && arg16 == 16'sh0004
		|=> err_code == ERR_WARNING && !st.amp_autoscale_enable && !out_set.amp_full)
		else $error("range command outside current mode not flagged");
	a_pend_range: assert property (cmd_go && op == OP_AMP_TRIG && crt_mag(arg16) > crt_mag(LEVEL_MAX)
		|=> err_code == ERR_RANGE && $stable(st.pend.amp))
		else $error("pending current over maximum accepted");
	a_trig_apply: assert property (cmd_go && op == OP_TRG && st.trig_init && mode == MODE_FIXED
		|=> out_set.amp == $past(st.pend.amp) && out_set.func == $past(st.pend.func))
		else $error("trigger did not apply pending values");
	a_list_end: assert property (mode == MODE_LIST && list_step.valid && list_step.last && !cmd_go
		|=> out_set.amp == $past(st.last_step.amp) && mode == MODE_FIXED)
		else $error("list end did not hold penultimate step");
	a_pulse_end: assert property (st.pulse_on ##1 !st.pulse_on && !$past(cmd_go)
		|-> out_set.amp == $past(st.prior_amp))
		else $error("transient did not restore prior level");
endmodule : crt_ctl

// ==== crt_list_src.sv ====
// Behavioural list sequencer that feeds steps to the controller
`timescale 1ns/1ps
module crt_list_src (
	input wire logic hclk,
	input wire logic hresetn,
	input wire crt_pkg::crt_list_type list_ctl,
	input wire logic [7:0] n_steps,
	input wire logic [7:0] gap,
	output crt_pkg::crt_step_type list_step
);
	import crt_pkg::*;
	logic run;
	logic [7:0] idx;
	logic [7:0] wait_cnt;
	logic [15:0] noise;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run <= 1'b0;
			idx <= 8'h00;
			wait_cnt <= 8'h00;
			noise <= 16'h5A5A;
			list_step <= '0;
		end else begin
			// Data is junk outside a valid step, so nothing may lean on it
			noise <= noise + 16'h3C3D;
			list_step.valid <= 1'b0;
			list_step.last <= 1'b0;
			list_step.volt <= noise;
			list_step.amp <= ~noise;
			if (list_ctl.abort) begin
				run <= 1'b0;
			end else if (list_ctl.start) begin
				run <= 1'b1;
				idx <= 8'h00;
				wait_cnt <= gap;
			end else if (run && wait_cnt != 8'h00) begin
				wait_cnt <= wait_cnt - 8'h01;
			end else if (run) begin
				list_step.valid <= 1'b1;
				list_step.last <= (idx == n_steps - 8'h01);
				list_step.volt <= 16'h0200 + {8'h00, idx};
				list_step.amp <= 16'h0100 + {8'h00, idx};
				idx <= idx + 8'h01;
				wait_cnt <= gap;
				run <= (idx != n_steps - 8'h01);
			end
		end
	end
endmodule : crt_list_src

// ==== crt_ctl_tb.sv ====
// Self-checking testbench for the mode, range and trigger controller
`timescale 1ns/1ps
module crt_ctl_tb;
	import crt_pkg::*;
	typedef struct {
		logic [31:0] exp;
		logic [31:0] mask;
		string name;
	} crt_note_type;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] n_steps = 8'h08;
	logic [7:0] gap = 8'h20;
	wire logic hready;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	crt_step_type list_step;
	crt_out_type out_set;
	crt_list_type list_ctl;
	crt_mode_type mode;
	logic err_pulse;
	logic signed [15:0] err_code;
	logic rd_phase = 1'b0;
	crt_note_type notes[$];
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	integer seed = 80;
	logic [15:0] base;
	logic [15:0] trig;
	assign hready = hreadyout;
	always #2 hclk = ~hclk;
	crt_ctl #(.TICKS_PER_MS(4)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .list_step(list_step), .out_set(out_set), .list_ctl(list_ctl),
		.mode(mode), .err_pulse(err_pulse), .err_code(err_code));
	crt_list_src i_src (.hclk(hclk), .hresetn(hresetn), .list_ctl(list_ctl), .n_steps(n_steps), .gap(gap),
		.list_step(list_step));
	task automatic print_verdict;
		$display("Comparisons %0d, errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	task automatic check_note(input logic [31:0] got);
		crt_note_type n;
		n = notes.pop_front();
		comparisons++;
		if ((got & n.mask) !== (n.exp & n.mask)) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n.name, n.exp & n.mask, got & n.mask);
		end
	endtask : check_note
	// Watcher: read data, limit at list start, list entry strobes and error pulses
	always @(posedge hclk) begin
		if (rd_phase && hreadyout === 1'b1 && notes.size() > 0) begin
			check_note(hrdata);
		end
		if (list_ctl.start === 1'b1 && notes.size() > 0) begin
			check_note({16'h0000, list_ctl.vlimit});
		end
		if (list_ctl.wr === 1'b1 && notes.size() > 0) begin
			check_note({15'h0000, list_ctl.wr_amp, list_ctl.data});
		end
		if (err_pulse === 1'b1 && notes.size() > 0) begin
			check_note(sx(err_code));
		end
		rd_phase <= hsel && htrans[1] && !hwrite && hready;
		cycles++;
		if (cycles == 20000) begin
			errors++;
			print_verdict();
		end
	end
	function automatic logic [31:0] sx(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction : sx
	// One transfer; a spare cycle before each keeps read-after-write visible
	task automatic bus(input logic [7:0] addr, input logic wr, input logic [31:0] data);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, addr};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= data;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask : bus
	task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input logic [31:0] mask, input string name);
		notes.push_back('{exp, mask, name});
		bus(addr, 1'b0, 32'h0);
	endtask : rd
	task automatic cmd(input crt_op_type op, input logic [31:0] arg);
		bus(OFS_ARG, 1'b1, arg);
		bus(OFS_CMD, 1'b1, 32'(op));
	endtask : cmd
	// Refused command: the error pulse is noted first, then the code is read and cleared
	task automatic err_is(input crt_op_type op, input logic [31:0] arg, input logic signed [15:0] code);
		notes.push_back('{sx(code), 32'hFFFF_FFFF, "error pulse"});
		cmd(op, arg);
		rd(OFS_ERROR, sx(code), 32'hFFFF_FFFF, "error");
		bus(OFS_ERROR, 1'b1, 32'h0);
	endtask : err_is
	initial begin
		base = 16'($random(seed)) & 16'h0FFF;
		trig = 16'($random(seed)) & 16'h0FFF;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd(OFS_STATUS, 32'h0000_0180, 32'h0000_C180, "status");
		cmd(OP_FUNC, 32'h1);
		cmd(OP_CURR, 32'h2000);
		rd(OFS_STATUS, 32'h1, 32'h7, "amp range");
		cmd(OP_CURR, 32'h1FFF);
		rd(OFS_STATUS, 32'h4, 32'h7, "amp range");
		cmd(OP_AMP_RANGE, 32'h1);
		rd(OFS_STATUS, 32'h1, 32'h87, "amp range");
		cmd(OP_AMP_RANGE, 32'h4);
		rd(OFS_STATUS, 32'h4, 32'h87, "amp range");
		err_is(OP_CURR, 32'h2000, ERR_RANGE);
		rd(OFS_AMP, 32'h1FFF, 32'hFFFF_FFFF, "amp");
		cmd(OP_FUNC, 32'h0);
		rd(OFS_STATUS, 32'h1, 32'h1007, "range after func");
		err_is(OP_AMP_RANGE, 32'h4, ERR_WARNING);
		cmd(OP_RST, 32'h0);
		rd(OFS_STATUS, 32'h0180, 32'hD180, "status");
		rd(OFS_AMP, 32'h0, 32'hFFFF_FFFF, "amp");
		cmd(OP_VOLT_AUTO, 32'h0);
		rd(OFS_STATUS, 32'h0, 32'h100, "volt auto");
		rd(OFS_STATUS, 32'h0040, 32'h0070, "volt range");
		cmd(OP_VOLT_RANGE, 32'h1);
		cmd(OP_AMP_AUTO, 32'h1);
		rd(OFS_STATUS, 32'h0090, 32'h01F0, "volt range");
		cmd(OP_CURR, {16'h0, base});
		cmd(OP_MODE_TRAN, 32'h2);
		rd(OFS_STATUS, 32'h4000, 32'hC000, "mode");
		cmd(OP_CURR, {16'h0, base + 16'h0100});
		rd(OFS_AMP, {16'h0, base + 16'h0100}, 32'hFFFF_FFFF, "pulse");
		rd(OFS_STATUS, 32'h0, 32'hC000, "mode");
		repeat (12) @(posedge hclk);
		rd(OFS_AMP, {16'h0, base}, 32'hFFFF_FFFF, "after pulse");
		err_is(OP_MODE_TRAN, 32'd10001, ERR_RANGE);
		rd(OFS_STATUS, 32'h0, 32'hC000, "mode");
		cmd(OP_AMP_TRIG, {16'h0, trig});
		cmd(OP_INIT, 32'h0);
		cmd(OP_MODE_TRAN, 32'h1);
		cmd(OP_TRG, 32'h0);
		rd(OFS_AMP, {16'h0, trig}, 32'hFFFF_FFFF, "trig pulse");
		repeat (12) @(posedge hclk);
		rd(OFS_AMP, {16'h0, base}, 32'hFFFF_FFFF, "after pulse");
		cmd(OP_RST, 32'h0);
		cmd(OP_CURR, {16'h0, base});
		cmd(OP_AMP_TRIG, {16'h0, trig});
		rd(OFS_AMP_PEND, {16'h0, trig}, 32'hFFFF_FFFF, "pending amp");
		err_is(OP_AMP_TRIG, 32'h8000, ERR_RANGE);
		rd(OFS_AMP_PEND, {16'h0, trig}, 32'hFFFF_FFFF, "pending amp");
		cmd(OP_TRG, 32'h0);
		rd(OFS_AMP, {16'h0, base}, 32'hFFFF_FFFF, "amp");
		cmd(OP_FUNC_TRIG, 32'h1);
		rd(OFS_STATUS, 32'h2000, 32'h2000, "pending func");
		cmd(OP_VOLT_TRIG, 32'h0011);
		cmd(OP_SAV, 32'h6);
		cmd(OP_AMP_TRIG, 32'h0033);
		cmd(OP_FUNC_TRIG, 32'h0);
		rd(OFS_STATUS, 32'h0, 32'h2000, "pending func");
		cmd(OP_RCL, 32'h6);
		rd(OFS_AMP_PEND, {16'h0, trig}, 32'hFFFF_FFFF, "recalled amp");
		rd(OFS_STATUS, 32'h2000, 32'h2000, "recalled func");
		rd(OFS_VOLT_PEND, 32'h0011, 32'hFFFF_FFFF, "recalled volt");
		cmd(OP_CURR, {16'h0, base});
		cmd(OP_INIT, 32'h0);
		cmd(OP_TRG, 32'h0);
		rd(OFS_AMP, {16'h0, trig}, 32'hFFFF_FFFF, "amp");
		rd(OFS_STATUS, 32'h1000, 32'h1000, "func");
		cmd(OP_INIT_CONT, 32'h1);
		repeat (2) begin
			cmd(OP_VOLT, 32'h0022);
			cmd(OP_CURR, {16'h0, base});
			cmd(OP_TRG, 32'h0);
			rd(OFS_AMP, {16'h0, trig}, 32'hFFFF_FFFF, "continuous amp");
			rd(OFS_VOLT, 32'h0011, 32'hFFFF_FFFF, "continuous volt");
		end
		cmd(OP_RST, 32'h0);
		cmd(OP_VOLT, 32'h0456);
		notes.push_back('{32'h0456, 32'hFFFF, "vlimit"});
		cmd(OP_MODE_LIST, 32'h0);
		rd(OFS_STATUS, 32'hC000, 32'hC000, "mode");
		err_is(OP_LIST_VOLT, 32'h5, ERR_CONFLICT);
		err_is(OP_FUNC, 32'h1, ERR_COMMAND);
		cmd(OP_MODE_FIX, 32'h0);
		rd(OFS_AMP, 32'h0, 32'hFFFF_FFFF, "amp");
		rd(OFS_VOLT, 32'h0, 32'hFFFF_FFFF, "volt");
		rd(OFS_STATUS, 32'h0, 32'hC000, "mode");
		notes.push_back('{32'h0001_0123, 32'h0001_FFFF, "list entry"});
		cmd(OP_LIST_CURR, 32'h0123);
		cmd(OP_VOLT, 32'h0456);
		n_steps <= 8'h04;
		gap <= 8'h01;
		notes.push_back('{32'h0456, 32'hFFFF, "vlimit"});
		cmd(OP_MODE_LIST, 32'h0);
		@(posedge hclk);
		for (int i = 0; i < 100 && mode !== MODE_FIXED; i++) @(posedge hclk);
		rd(OFS_AMP, 32'h0102, 32'hFFFF_FFFF, "list end amp");
		rd(OFS_STATUS, 32'h0, 32'hC000, "mode");
		repeat (4) @(posedge hclk);
		print_verdict();
	end
endmodule : crt_ctl_tb
